/* File: design/bsq_cfg.svh */
// Function
// - Triggered mode, the default, emits exactly the set cycle count per trigger.
// - Gated mode runs while gate is true, then finishes the cycle and holds.
// - A noise waveform in gated mode stops at once when the gate drops.
// - A setting chooses whether the gate is true at high or low level.
// - Gated mode ignores count, interval and source; manual triggers drop silently.
// - Cycle count accepts 1 to 1,000,000 or infinite; resets to one.
// - Count readback gives the stored count or a special infinite code.
// - Internal source needs count below interval times frequency; else raise interval.
// - Sine and square above 25 MHz need an infinite cycle count.
// - A count written in gated mode is kept and used when triggered returns.
// - Interval is start-to-start, 1 us to 500 s, reset 10 ms.
// - Interval is used only with internal source in triggered mode.
// - Interval must exceed count over frequency plus 200 ns; else lengthen.
// - Internally triggered bursts refuse frequencies below 2 mHz.
// - Sine, square, ramp, pulse, arbitrary allowed; noise only gated; never dc.
// - Start phase accepts -360 to +360 degrees in both modes.
// - Bursts start from interval timer, panel key, external edge or host command.
// - Gate polarity resets to true-high.
// - External edges arriving during a running burst are ignored.
`ifndef BSQ_CFG_SVH
`define BSQ_CFG_SVH

`define BSQ_A_CTRL      8'h00
`define BSQ_A_CMD       8'h04
`define BSQ_A_COUNT     8'h08
`define BSQ_A_INTERVAL  8'h0C
`define BSQ_A_PHASE     8'h10
`define BSQ_A_SHAPE     8'h14
`define BSQ_A_FREQ_HZ   8'h18
`define BSQ_A_FREQ_MHZ  8'h1C
`define BSQ_A_STATUS    8'h20
`define BSQ_A_ERRORS    8'h24

`define BSQ_CTRL_EN     0
`define BSQ_CTRL_MODE   1
`define BSQ_CTRL_SRC    2
`define BSQ_CTRL_POL    4
`define BSQ_CMD_TRIG    0
`define BSQ_ERR_CONFL   0
`define BSQ_ERR_RANGE   1
`define BSQ_ERR_REJECT  2

`define BSQ_RST_COUNT    20'h00001
`define BSQ_RST_INTERVAL 29'h00002710
`define BSQ_RST_FREQ_HZ  27'h00003E8
`define BSQ_COUNT_MAX    20'hF4240
`define BSQ_INT_MIN      29'h00000001
`define BSQ_INT_MAX      29'h1DCD6500
`define BSQ_PHASE_LIM    10'h168
`define BSQ_FAST_HZ      27'h17D7840
`define BSQ_SLOW_MHZ     10'h002
`define BSQ_MHZ_MAX      10'h3E7
`define BSQ_INF_CODE     32'hFFFFFFFF
`define BSQ_MHZ_PER_HZ   37'h00000003E8
`define BSQ_CYC_SCALE    54'h000000003B9ACA00

`define BSQ_CLK_NS      50
`define BSQ_US_NS       1000
`define BSQ_GUARD_NS    200
`define BSQ_US_CYCLES   (`BSQ_US_NS / `BSQ_CLK_NS)
`define BSQ_GUARD_DIV   (`BSQ_US_NS / `BSQ_GUARD_NS)

`endif

/* File: design/bsq_div.sv */
`timescale 1ns/1ps
`default_nettype none
module bsq_div import bsq_pkg::*; (
  input  wire logic        hclk,    // System clock
  input  wire logic        hresetn, // Async reset, active low
  input  wire logic        ce,      // Clock enable
  input  wire logic        start,   // Begin a division
  input  wire logic [53:0] num,     // Dividend
  input  wire logic [39:0] den,     // Divisor, nonzero
  output logic             done,    // Quotient valid pulse
  output logic      [53:0] quo      // Quotient
);
  bsq_div_s_t q;
  bsq_div_s_t d;

  // Restoring division, one quotient bit per clock: 54 cycles trades speed for area
  // A new start abandons a running division, so the newest settings always win
  always_comb begin
    logic [40:0] t;
    t = 41'h0;
    d = q;
    if (ce) begin
      d.done = 1'b0;
      if (start) begin
        d.rem  = 41'h0;
        d.quo  = num;
        d.cnt  = 6'h36;
        d.busy = 1'b1;
      end else if (q.busy) begin
        t = {q.rem[39:0], q.quo[53]};
        if (t >= {1'b0, den}) begin
          d.rem = t - {1'b0, den};
          d.quo = {q.quo[52:0], 1'b1};
        end else begin
          d.rem = t;
          d.quo = {q.quo[52:0], 1'b0};
        end
        d.cnt = q.cnt - 6'h01;
        if (q.cnt == 6'h01) begin
          d.busy = 1'b0;
          d.done = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = q.done;
  assign quo  = q.quo;
endmodule
`default_nettype wire

/* File: design/bsq_pkg.sv */
package bsq_pkg;
  typedef enum logic {BSQ_TRIGGERED = 1'b0, BSQ_GATED = 1'b1} bsq_mode_t;
  typedef enum logic [1:0] {BSQ_SRC_INT = 2'h0, BSQ_SRC_EXT = 2'h1, BSQ_SRC_BUS = 2'h2} bsq_src_t;
  typedef enum logic [2:0] {
    BSQ_SINE = 3'h0, BSQ_SQUARE = 3'h1, BSQ_RAMP = 3'h2, BSQ_PULSE = 3'h3,
    BSQ_ARB = 3'h4, BSQ_NOISE = 3'h5, BSQ_DC = 3'h6
  } bsq_shape_t;
  typedef enum logic [1:0] {
    BSQ_IDLE = 2'h0, BSQ_BURST = 2'h1, BSQ_FINISH = 2'h3, BSQ_GATED_RUN = 2'h2
  } bsq_state_t;

  typedef struct packed {
    logic        enable;
    bsq_mode_t   mode;
    bsq_src_t    src;
    logic        gate_low;
    logic [19:0] count;
    logic        count_inf;
    logic [28:0] interval;
    logic [9:0]  phase;
    bsq_shape_t  shape;
    logic [26:0] f_hz;
    logic [9:0]  f_mhz;
    logic [2:0]  err;
    bsq_state_t  st;
    logic [19:0] left;
    logic [33:0] timer;
    logic        adj_go;
    logic        adj_busy;
    logic        adj_cause_cnt;
    logic        trig_prev;
    logic [7:0]  addr;
    logic        wr_pend;
    logic        rd_pend;
    logic        hready;
    logic [31:0] hrdata;
    logic        run;
    logic        busy;
  } bsq_state_s_t;

  typedef struct packed {
    logic [40:0] rem;
    logic [53:0] quo;
    logic [5:0]  cnt;
    logic        busy;
    logic        done;
  } bsq_div_s_t;
endpackage

/* File: design/bsq_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module bsq_sync import bsq_pkg::*; (
  input  wire logic       hclk,     // System clock
  input  wire logic       hresetn,  // Async reset, active low
  input  wire logic       ce,       // Clock enable
  input  wire logic [1:0] async_in, // Trigger and gate pins
  output logic      [1:0] sync_out  // Synchronised levels
);
  logic [3:0] q;
  logic [3:0] d;

  // Second stage only is visible outside; first stage feeds nothing else
  always_comb begin
    d = q;
    if (ce) begin
      d = {q[1:0], async_in};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= 4'h0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q[3:2];
endmodule
`default_nettype wire

/* File: design/bsq_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bsq_cfg.svh"
module bsq_top import bsq_pkg::*; (
  input  wire logic        hclk,          // System clock, 20 MHz
  input  wire logic        hresetn,       // Async reset, active low
  input  wire logic        ce,            // Clock enable, freezes all state
  input  wire logic        hsel,          // Slave select
  input  wire logic [31:0] haddr,         // Byte address
  input  wire logic [1:0]  htrans,        // Transfer type
  input  wire logic        hwrite,        // Write when high
  input  wire logic [2:0]  hsize,         // Transfer size, word only
  input  wire logic [31:0] hwdata,        // Write data
  input  wire logic        hready,        // Bus ready
  output logic      [31:0] hrdata,        // Read data
  output logic             hreadyout,     // Slave ready
  output logic             hresp,         // Always OKAY
  input  wire logic        ext_trig_in,   // External trigger / gate pin
  input  wire logic        panel_key,     // Front-panel trigger key pulse
  input  wire logic        wave_cycle_end,// Synthesis finished one cycle at start phase
  output logic             wave_run,      // Run waveform synthesis
  output logic             burst_busy,    // Burst or gated run in progress
  output logic      [9:0]  start_phase,   // Start phase, signed degrees
  output logic      [2:0]  wave_shape,    // Selected waveform
  output logic      [26:0] wave_freq_hz,  // Frequency, whole hertz
  output logic      [9:0]  wave_freq_mhz  // Frequency, millihertz part
);
  bsq_state_s_t q;
  bsq_state_s_t n;
  logic [1:0]   sync_lvl;
  logic         div_done;
  logic [53:0]  div_quo;
  logic [36:0]  f_total;
  logic [53:0]  div_num;
  logic [39:0]  div_den;

  bsq_sync u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .async_in ({ext_trig_in, ext_trig_in}),
    .sync_out (sync_lvl)
  );

  // Least interval in us is floor((k*count*1e9 + f) / (k*f)) + 1, k = 1 us / 200 ns
  // Frequency in millihertz; 37 bits hold the largest storable frequency
  assign f_total = {10'h0, q.f_hz} * `BSQ_MHZ_PER_HZ + {27'h0, q.f_mhz};
  assign div_num = 54'(`BSQ_GUARD_DIV) * {34'h0, q.count} * `BSQ_CYC_SCALE
                   + {17'h0, f_total};
  assign div_den = 40'(`BSQ_GUARD_DIV) * {3'h0, f_total};

  bsq_div u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .start   (q.adj_go),
    .num     (div_num),
    .den     (div_den),
    .done    (div_done),
    .quo     (div_quo)
  );

  // Start-to-start timing exists only for triggered mode with the internal source
  function automatic logic burst_timed(bsq_mode_t md, logic [1:0] sr);
    burst_timed = (md == BSQ_TRIGGERED) && (sr == BSQ_SRC_INT);
  endfunction

  function automatic logic cfg_ok(bsq_shape_t sh, bsq_mode_t md, logic [1:0] sr,
                                  logic inf, logic [26:0] hz, logic [9:0] mhz);
    logic fast;
    logic slow;
    fast = (hz > `BSQ_FAST_HZ) || (hz == `BSQ_FAST_HZ && mhz != 10'h0);
    slow = (hz == 27'h0) && (mhz < `BSQ_SLOW_MHZ);
    cfg_ok = (sh != BSQ_DC) && (sh <= BSQ_DC)
             && !(sh == BSQ_NOISE && md != BSQ_GATED)
             && !((sh == BSQ_SINE || sh == BSQ_SQUARE) && fast && !inf)
             && !(burst_timed(md, sr) && slow)
             && (sr != 2'h3) && (mhz <= `BSQ_MHZ_MAX);
  endfunction

  function automatic logic [31:0] rd_word(bsq_state_s_t s, logic [1:0] lvl);
    case (s.addr)
      `BSQ_A_CTRL:     rd_word = {27'h0, s.gate_low, s.src, s.mode, s.enable};
      `BSQ_A_COUNT:    rd_word = s.count_inf ? `BSQ_INF_CODE : {12'h0, s.count};
      `BSQ_A_INTERVAL: rd_word = {3'h0, s.interval};
      `BSQ_A_PHASE:    rd_word = {{22{s.phase[9]}}, s.phase};
      `BSQ_A_SHAPE:    rd_word = {29'h0, s.shape};
      `BSQ_A_FREQ_HZ:  rd_word = {5'h0, s.f_hz};
      `BSQ_A_FREQ_MHZ: rd_word = {22'h0, s.f_mhz};
      `BSQ_A_STATUS:   rd_word = {27'h0, lvl[1], s.adj_busy, s.st, s.run};
      `BSQ_A_ERRORS:   rd_word = {29'h0, s.err};
      default:         rd_word = 32'h0;
    endcase
  endfunction

  always_comb begin
    logic        soft_trig;
    logic        trig_hit;
    logic        gate_on;
    logic        ext_edge;
    logic [2:0]  err_set;
    logic [2:0]  err_clr;
    logic        check;
    logic [53:0] need;
    logic [9:0]  ph;
    logic [19:0] cnt;
    bsq_shape_t  sh;
    bsq_mode_t   md;
    soft_trig = 1'b0;
    trig_hit  = 1'b0;
    err_set   = 3'h0;
    err_clr   = 3'h0;
    check     = 1'b0;
    need      = 54'h0;
    ph        = hwdata[9:0];
    cnt       = hwdata[19:0];
    sh        = bsq_shape_t'(hwdata[2:0]);
    md        = bsq_mode_t'(hwdata[`BSQ_CTRL_MODE]);
    n         = q;
    gate_on   = q.gate_low ? !sync_lvl[1] : sync_lvl[1];
    // Edges come from the synchronised level, never from the raw pin
    ext_edge  = sync_lvl[0] && !q.trig_prev;
    if (ce) begin
      n.trig_prev = sync_lvl[0];
      n.adj_go    = 1'b0;
      // Register writes land at the end of the data phase; an invalid value is
      // refused whole so the stored set never holds a forbidden combination.
      if (q.wr_pend) begin
        n.wr_pend = 1'b0;
        case (q.addr)
          `BSQ_A_CTRL: begin
            if (cfg_ok(q.shape, md, hwdata[3:2], q.count_inf, q.f_hz, q.f_mhz)) begin
              n.enable   = hwdata[`BSQ_CTRL_EN];
              n.mode     = md;
              n.src      = bsq_src_t'(hwdata[3:2]);
              n.gate_low = hwdata[`BSQ_CTRL_POL];
              check      = 1'b1;
            end else begin
              err_set[`BSQ_ERR_REJECT] = 1'b1;
            end
          end
          `BSQ_A_CMD: soft_trig = hwdata[`BSQ_CMD_TRIG];
          `BSQ_A_COUNT: begin
            if (hwdata == `BSQ_INF_CODE &&
                cfg_ok(q.shape, q.mode, q.src, 1'b1, q.f_hz, q.f_mhz)) begin
              n.count_inf = 1'b1;
            end else if (hwdata[31:20] == 12'h0 && cnt != 20'h0 &&
                         cnt <= `BSQ_COUNT_MAX &&
                         cfg_ok(q.shape, q.mode, q.src, 1'b0, q.f_hz, q.f_mhz)) begin
              n.count         = cnt;
              n.count_inf     = 1'b0;
              n.adj_cause_cnt = 1'b1;
              check           = 1'b1;
            end else begin
              err_set[`BSQ_ERR_REJECT] = 1'b1;
            end
          end
          `BSQ_A_INTERVAL: begin
            if (hwdata[31:29] == 3'h0 && hwdata[28:0] >= `BSQ_INT_MIN &&
                hwdata[28:0] <= `BSQ_INT_MAX) begin
              n.interval      = hwdata[28:0];
              n.adj_cause_cnt = 1'b0;
              check           = 1'b1;
            end else begin
              err_set[`BSQ_ERR_REJECT] = 1'b1;
            end
          end
          `BSQ_A_PHASE: begin
            if ($signed(hwdata) >= -$signed({22'h0, `BSQ_PHASE_LIM}) &&
                $signed(hwdata) <= $signed({22'h0, `BSQ_PHASE_LIM})) begin
              n.phase = ph;
            end else begin
              err_set[`BSQ_ERR_REJECT] = 1'b1;
            end
          end
          `BSQ_A_SHAPE: begin
            if (hwdata[31:3] == 29'h0 &&
                cfg_ok(sh, q.mode, q.src, q.count_inf, q.f_hz, q.f_mhz)) begin
              n.shape = sh;
            end else begin
              err_set[`BSQ_ERR_REJECT] = 1'b1;
            end
          end
          `BSQ_A_FREQ_HZ: begin
            if (hwdata[31:27] == 5'h0 &&
                cfg_ok(q.shape, q.mode, q.src, q.count_inf, hwdata[26:0], q.f_mhz)) begin
              n.f_hz = hwdata[26:0];
              check  = 1'b1;
            end else begin
              err_set[`BSQ_ERR_REJECT] = 1'b1;
            end
          end
          `BSQ_A_FREQ_MHZ: begin
            if (hwdata[31:10] == 22'h0 &&
                cfg_ok(q.shape, q.mode, q.src, q.count_inf, q.f_hz, hwdata[9:0])) begin
              n.f_mhz = hwdata[9:0];
              check   = 1'b1;
            end else begin
              err_set[`BSQ_ERR_REJECT] = 1'b1;
            end
          end
          `BSQ_A_ERRORS: err_clr = hwdata[2:0];
          default: ;
        endcase
      end
      // Interval check only matters for internally triggered finite bursts
      // A check while the divider runs restarts it, so no stored value goes unchecked
      if (check && burst_timed(n.mode, n.src) && !n.count_inf) begin
        n.adj_go   = 1'b1;
        n.adj_busy = 1'b1;
      end
      if (div_done) begin
        n.adj_busy = n.adj_go;
        need       = div_quo + 54'h1;
        if (need > {25'h0, q.interval}) begin
          n.interval = (need > {25'h0, `BSQ_INT_MAX}) ? `BSQ_INT_MAX : need[28:0];
          if (q.adj_cause_cnt) begin
            err_set[`BSQ_ERR_CONFL] = 1'b1;
          end else begin
            err_set[`BSQ_ERR_RANGE] = 1'b1;
          end
        end
      end
      // A new error in the clearing cycle survives the clear
      n.err = (q.err & ~err_clr) | err_set;

      // Start-to-start timer runs only for internal source in triggered mode
      if (q.enable && burst_timed(q.mode, q.src)) begin
        if (q.timer == 34'h0) begin
          trig_hit = 1'b1;
          // Reloading as it fires keeps the spacing start-to-start
          n.timer  = 34'({5'h0, q.interval} * `BSQ_US_CYCLES) - 34'h1;
        end else begin
          n.timer = q.timer - 34'h1;
        end
      end else begin
        n.timer = 34'h0;
      end
      if (q.mode == BSQ_TRIGGERED) begin
        if (q.src == BSQ_SRC_EXT && ext_edge) begin
          trig_hit = 1'b1;
        end
        if (q.src == BSQ_SRC_BUS && (soft_trig || panel_key)) begin
          trig_hit = 1'b1;
        end
      end

      case (q.st)
        BSQ_IDLE: begin
          // Triggers are looked at only here; any arriving mid-burst are lost
          if (q.enable && q.mode == BSQ_GATED && gate_on) begin
            n.st  = BSQ_GATED_RUN;
            n.run = 1'b1;
          end else if (q.enable && q.mode == BSQ_TRIGGERED && trig_hit) begin
            n.st   = BSQ_BURST;
            n.left = q.count;
            n.run  = 1'b1;
          end
        end
        BSQ_BURST: begin
          // Triggers arriving here are not looked at
          // Leaving triggered mode mid-burst still ends on a whole cycle
          if (!q.enable || q.mode != BSQ_TRIGGERED) begin
            n.st = BSQ_FINISH;
          end else if (wave_cycle_end && !q.count_inf) begin
            if (q.left == 20'h1) begin
              n.st  = BSQ_IDLE;
              n.run = 1'b0;
            end else begin
              n.left = q.left - 20'h1;
            end
          end
        end
        BSQ_GATED_RUN: begin
          if (!gate_on || !q.enable || q.mode != BSQ_GATED) begin
            // Noise has no phase to return to, so it stops at once
            if (q.shape == BSQ_NOISE) begin
              n.st  = BSQ_IDLE;
              n.run = 1'b0;
            end else begin
              n.st = BSQ_FINISH;
            end
          end
        end
        BSQ_FINISH: begin
          if (wave_cycle_end || q.shape == BSQ_NOISE) begin
            n.st  = BSQ_IDLE;
            n.run = 1'b0;
          end
        end
        default: begin
          n.st  = BSQ_IDLE;
          n.run = 1'b0;
        end
      endcase
      // Busy leaves a flop so the pin never glitches on a state change
      n.busy = (n.st != BSQ_IDLE);

      // Reads take one wait state so a write just before is always seen
      if (q.rd_pend) begin
        n.rd_pend = 1'b0;
        n.hready  = 1'b1;
        n.hrdata  = rd_word(q, sync_lvl);
      end else if (hsel && htrans[1] && hready) begin
        n.addr    = {haddr[7:2], 2'b00};
        n.wr_pend = hwrite;
        n.rd_pend = !hwrite;
        n.hready  = hwrite;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q          <= '0;
      q.mode     <= BSQ_TRIGGERED;
      q.src      <= BSQ_SRC_INT;
      q.gate_low <= 1'b0;
      q.count    <= `BSQ_RST_COUNT;
      q.interval <= `BSQ_RST_INTERVAL;
      q.shape    <= BSQ_SINE;
      q.f_hz     <= `BSQ_RST_FREQ_HZ;
      q.st       <= BSQ_IDLE;
      q.hready   <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign hrdata        = q.hrdata;
  assign hreadyout     = q.hready;
  // Every access ends OKAY; refused values show in the error register instead
  assign hresp         = 1'b0;
  assign wave_run      = q.run;
  assign burst_busy    = q.busy;
  assign start_phase   = q.phase;
  assign wave_shape    = q.shape;
  assign wave_freq_hz  = q.f_hz;
  assign wave_freq_mhz = q.f_mhz;
endmodule
`default_nettype wire

/* File: verif/bsq_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bsq_far_model #(parameter int PERIOD = 5) (
  input  wire logic hclk,           // Clock
  input  wire logic hresetn,        // Reset, active low
  input  wire logic wave_run,       // Run request
  input  wire logic stall,          // Slow synthesis, no cycle ends
  input  wire logic pin_lvl,        // Wanted pin level
  output logic      ext_trig_in,    // Trigger or gate pin
  output logic      wave_cycle_end  // One cycle completed
);
  logic [7:0] ph_q;
  assign ext_trig_in = pin_lvl;
  assign wave_cycle_end = wave_run && !stall && ph_q == 8'(PERIOD - 1);
  // Restart at the start phase whenever synthesis is halted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ph_q <= 8'h00;
    else if (!wave_run || wave_cycle_end) ph_q <= 8'h00;
    else if (!stall) ph_q <= ph_q + 8'h01;
  end
endmodule
`default_nettype wire

/* File: verif/bsq_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module bsq_monitor import bsq_pkg::*; (
  input wire logic       hclk,           // Clock
  input wire logic       hresetn,        // Reset, active low
  input wire logic       ce,             // Clock enable
  input wire logic       hsel,           // Select
  input wire logic [1:0] htrans,         // Transfer type
  input wire logic       hwrite,         // Write
  input wire logic       hready,         // Bus ready
  input wire logic       hreadyout,      // Slave ready
  input wire logic       hresp,          // Response
  input wire logic       wave_cycle_end, // Cycle done
  input wire logic       wave_run,       // Run
  input wire logic       burst_busy,     // Busy
  input wire logic [9:0] start_phase,    // Phase
  input wire logic [2:0] wave_shape      // Shape
);
  default clocking cb @(posedge hclk); endclocking
  // A frozen clock enable stalls everything, so nothing is judged then
  default disable iff (!hresetn || !ce);
  logic taken;
  assign taken = hsel && htrans[1] && hready;
  read_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (taken && hwrite |=> hreadyout)
    else $error("write stalled");
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  run_busy_a: assert property (wave_run |-> burst_busy)
    else $error("run without busy");
  whole_cycle_a: assert property (
    $fell(wave_run) && $past(wave_shape) != BSQ_NOISE |-> $past(wave_cycle_end))
    else $error("run stopped mid cycle");
  busy_end_a: assert property ($fell(burst_busy) |-> $fell(wave_run))
    else $error("busy dropped apart from run");
  fresh_start_a: assert property ($rose(wave_run) |-> $rose(burst_busy))
    else $error("run started inside a burst");
  phase_range_a: assert property (
    $signed(start_phase) >= -360 && $signed(start_phase) <= 360)
    else $error("phase out of range");
  no_dc_a: assert property (wave_shape != BSQ_DC)
    else $error("dc shape selected");
  cover property ($rose(wave_run));
  cover property ($fell(wave_run) && wave_shape == BSQ_NOISE);
  cover property (taken && !hwrite);
endmodule
bind bsq_top bsq_monitor i_bsq_monitor (.hclk(hclk), .hresetn(hresetn), .ce(ce),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .wave_cycle_end(wave_cycle_end),
  .wave_run(wave_run), .burst_busy(burst_busy), .start_phase(start_phase),
  .wave_shape(wave_shape));
`default_nettype wire

/* File: verif/waveform_burst_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module waveform_burst_sequencer_tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, ext_trig_in, wave_cycle_end, wave_run, burst_busy;
  logic [9:0]  start_phase, wave_freq_mhz;
  logic [2:0]  wave_shape;
  logic [26:0] wave_freq_hz;
  logic        panel_key = 1'b0, pin = 1'b0, stall = 1'b0, run_p = 1'b0;
  int          failures = 0, comparisons = 0, ends_n = 0, rises_n = 0, cyc = 0;
  always #25 hclk = ~hclk;
  bsq_top i_bsq_top (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ext_trig_in(ext_trig_in), .panel_key(panel_key), .wave_cycle_end(wave_cycle_end),
    .wave_run(wave_run), .burst_busy(burst_busy), .start_phase(start_phase),
    .wave_shape(wave_shape), .wave_freq_hz(wave_freq_hz), .wave_freq_mhz(wave_freq_mhz));
  bsq_far_model #(.PERIOD(5)) i_bsq_far_model (.hclk(hclk), .hresetn(hresetn),
    .wave_run(wave_run), .stall(stall), .pin_lvl(pin), .ext_trig_in(ext_trig_in),
    .wave_cycle_end(wave_cycle_end));
  always @(posedge hclk) begin
    cyc++;
    ends_n += wave_cycle_end;
    if (wave_run && !run_p) rises_n++;
    run_p = wave_run;
    if (cyc > 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic t_reset();
    logic [7:0]  a[6] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h3C};
    logic [31:0] e[6] = '{32'h0, 32'h1, 32'h2710, 32'h0, 32'h0, 32'h0};
    `CHK(wave_run, 1'b0)
    for (int i = 0; i < 6; i++) rdc(a[i], e[i]);
  endtask
  task automatic t_refuse();
    logic [7:0]  a[8] = '{8'h14, 8'h14, 8'h18, 8'h08, 8'h08, 8'h10, 8'h18, 8'h1C};
    logic [31:0] d[8] = '{32'h6, 32'h5, 32'h1C9C380, 32'h0, 32'hF4241, 32'h169, 32'h0, 32'h3E8};
    for (int i = 0; i < 8; i++) begin
      wr(a[i], d[i]);
      rdc(8'h24, 32'h4);
      wr(8'h24, 32'h7);
    end
    `CHK(wave_shape, 3'h0)
    `CHK(wave_freq_hz, 27'h3E8)
    wr(8'h10, 32'hFFFFFE98);
    wr(8'h1C, 32'h1F4);
    settle(2);
    `CHK(start_phase, 10'h298)
    `CHK(wave_freq_mhz, 10'h1F4)
    wr(8'h10, 32'h0);
    wr(8'h1C, 32'h0);
    wr(8'h08, 32'hFFFFFFFF);
    rdc(8'h08, 32'hFFFFFFFF);
    wr(8'h08, 32'h1);
    rdc(8'h24, 32'h0);
  endtask
  task automatic t_adjust();
    wr(8'h08, 32'hF4240);
    settle(80);
    rdc(8'h08, 32'hF4240);
    rdc(8'h0C, 32'h1DCD6500);
    rdc(8'h24, 32'h1);
    wr(8'h24, 32'h7);
    wr(8'h08, 32'h1);
    wr(8'h18, 32'hF4240);
    wr(8'h0C, 32'h1);
    settle(80);
    rdc(8'h0C, 32'h2);
    rdc(8'h24, 32'h2);
    wr(8'h24, 32'h7);
  endtask
  task automatic t_internal();
    wr(8'h0C, 32'h5);
    settle(80);
    rdc(8'h0C, 32'h5);
    rises_n = 0;
    ends_n = 0;
    wr(8'h00, 32'h1);
    settle(250);
    wr(8'h00, 32'h0);
    settle(20);
    `CHK(rises_n, 3)
    `CHK(ends_n, 3)
  endtask
  task automatic t_gated();
    wr(8'h00, 32'h3);
    wr(8'h08, 32'h3);
    wr(8'h04, 32'h1);
    rdc(8'h24, 32'h0);
    `CHK(wave_run, 1'b0)
    pin <= 1'b1;
    settle(6);
    `CHK(wave_run, 1'b1)
    stall <= 1'b1;
    pin <= 1'b0;
    settle(8);
    `CHK(wave_run, 1'b1)
    `CHK(burst_busy, 1'b1)
    stall <= 1'b0;
    settle(10);
    `CHK(wave_run, 1'b0)
    `CHK(burst_busy, 1'b0)
    wr(8'h00, 32'h13);
    settle(6);
    `CHK(wave_run, 1'b1)
    wr(8'h14, 32'h5);
    stall <= 1'b1;
    pin <= 1'b1;
    settle(6);
    `CHK(wave_run, 1'b0)
    stall <= 1'b0;
    wr(8'h14, 32'h0);
    pin <= 1'b0;
  endtask
  task automatic t_bus();
    wr(8'h00, 32'h9);
    settle(20);
    ends_n = 0;
    rises_n = 0;
    wr(8'h04, 32'h1);
    wr(8'h04, 32'h1);
    settle(40);
    `CHK(ends_n, 3)
    `CHK(rises_n, 1)
    panel_key <= 1'b1;
    settle(1);
    panel_key <= 1'b0;
    settle(40);
    `CHK(rises_n, 2)
  endtask
  task automatic t_ext();
    wr(8'h00, 32'h5);
    settle(4);
    ends_n = 0;
    pin <= 1'b1;
    settle(4);
    pin <= 1'b0;
    settle(4);
    pin <= 1'b1;
    settle(4);
    pin <= 1'b0;
    settle(40);
    `CHK(ends_n, 3)
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_refuse();
    t_adjust();
    t_internal();
    t_gated();
    t_bus();
    t_ext();
    tally_and_finish();
  end
endmodule
`default_nettype wire
